// ### tb.sv
// Self-checking bench for the test point port.
// Assumes the strap model resolves the pins; inputs change on the falling clock edge.
`timescale 1ns/10ps
module tb;
  import tpp_pkg::*;
  logic                clk = 1'h0;
  logic                rst = 1'h1;
  logic                sys_rst_n = 1'h0;
  logic [7:0]          pin_lvl, port_o, port_oe, pd_en, strap_value;
  logic [7:0]          jumper_pu = 8'h00;
  logic                ce = 1'h1;
  logic [7:0]          sel_mask = 8'h00;
  logic                ck_fast = 1'h0, ck_half = 1'h0, ck_var = 1'h0, ck_slow = 1'h0;
  logic                sel_wr = 1'h0;
  tpp_sel_t            sel_code = tpp_sel_t'(24'h0);
  logic [3:0]          mode_opt;
  logic                port_active;
  int                  miscompares = 0, samples_checked = 0, cycles = 0;

  always #20 clk = ~clk;

  tpp_test_point_port #(.N_PINS(8)) dut (
    .CLK(clk), .RST(rst), .CE(ce), .SYSTEM_RESET_N(sys_rst_n),
    .TEST_POINT_PORT_I(pin_lvl), .TEST_POINT_PORT_O(port_o), .TEST_POINT_PORT_OE(port_oe),
    .TEST_POINT_PORT_PD_EN(pd_en), .CORE_CLK_FAST(ck_fast), .CORE_CLK_HALF(ck_half),
    .CORE_CLK_VAR(ck_var), .CORE_CLK_SLOW(ck_slow), .SEL_WR(sel_wr), .SEL_MASK(sel_mask),
    .SEL_CODE(sel_code), .MODE_OPT(mode_opt), .STRAP_VALUE(strap_value), .PORT_ACTIVE(port_active));

  tpp_strap_model board (.oe(port_oe), .drv(port_o), .pd_en(pd_en), .jumper_pu(jumper_pu), .pin(pin_lvl));

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Whole run is about 135 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 3000) begin
      miscompares++;
      results();
    end
  end

  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask

  // Release takes four edges through the synchroniser; six leaves the outputs settled
  task automatic do_release(logic [7:0] pu);
    jumper_pu = pu;
    sys_rst_n = 1'h0;
    tick(5);
    sys_rst_n = 1'h1;
    tick(6);
  endtask

  task automatic sw_write(logic [7:0] mask, tpp_sel_t code);
    sel_wr = 1'h1;
    sel_mask = mask;
    sel_code = code;
    tick(1);
    sel_wr = 1'h0;
    // Let one edge pass so a following write never re-raises the strobe in the same step
    tick(1);
  endtask

  task automatic t_hold();
    jumper_pu = 8'h05;
    tick(5);
    chk("oe in reset", 8'h00, port_oe);
    chk("pull-down", 8'hFF, pd_en);
    chk("active in reset", 8'h00, {7'h0, port_active});
    sw_write(8'hFF, tpp_sel_t'({8{TPP_SRC_HIGH}}));
    tick(1);
    chk("write in reset", 8'h00, port_oe);
  endtask

  task automatic t_quiet();
    do_release(8'h88);
    chk("quiet strap", 8'h88, strap_value);
    chk("quiet oe", 8'h00, port_oe);
    chk("quiet option", 8'h01, {4'h0, mode_opt});
    chk("quiet active", 8'h01, {7'h0, port_active});
    jumper_pu = 8'h02;
    tick(8);
    chk("late strap", 8'h88, strap_value);
    chk("late oe", 8'h00, port_oe);
  endtask

  task automatic t_clkdbg();
    logic [7:0] exp;
    do_release(8'h7A);
    chk("debug oe", 8'hFF, port_oe);
    chk("debug option", 8'h0F, {4'h0, mode_opt});
    for (int k = 0; k < 16; k++) begin
      {ck_slow, ck_var, ck_half, ck_fast} = 4'(k);
      #1;
      exp = {ck_slow, 1'h1, 1'h1, 1'h0, 1'h1, ck_var, ck_half, ck_fast};
      chk("debug levels", exp, port_o);
      tick(1);
    end
  endtask

  task automatic t_soft();
    tpp_sel_t   code;
    logic [3:0] pat [3] = '{4'h9, 4'hA, 4'h4};
    logic [7:0] lvl [3] = '{8'h4C, 8'h54, 8'h24};
    do_release(8'h02);
    {ck_slow, ck_var, ck_half, ck_fast} = 4'h0;
    code = tpp_sel_t'(24'h0);
    code[0] = TPP_SRC_HIGH;
    sw_write(8'h01, code);
    chk("first write", 8'h01, {7'h0, port_o[0] & port_oe[0]});
    code[1] = TPP_SRC_HIZ;
    code[4] = TPP_SRC_HIGH;
    sw_write(8'h12, code);
    chk("masked oe", 8'hFD, port_oe);
    chk("masked level", 8'h79, port_o);
    // A write with the clock enable low must leave the selection untouched
    ce = 1'h0;
    code[0] = TPP_SRC_LOW;
    sw_write(8'h01, code);
    ce = 1'h1;
    chk("frozen level", 8'h79, port_o);
    chk("frozen oe", 8'hFD, port_oe);
    // Three clock patterns give every source code its own level and enable signature
    for (int c = 0; c < 7; c++) begin
      code[7] = tpp_src_t'(c);
      sw_write(8'h80, code);
      for (int p = 0; p < 3; p++) begin
        {ck_slow, ck_var, ck_half, ck_fast} = pat[p];
        #1;
        chk("pin7 code", {6'h0, c != 0, lvl[p][c]}, {6'h0, port_oe[7], port_o[7]});
        tick(1);
      end
    end
    sys_rst_n = 1'h0;
    tick(5);
    chk("reentry oe", 8'h00, port_oe);
    do_release(8'h00);
    chk("override cleared", 8'h00, port_oe);
  endtask

  initial begin
    tick(12);
    rst = 1'h0;
    t_hold();
    t_quiet();
    t_clkdbg();
    t_soft();
    results();
  end
endmodule

// ### tpp_pin_if.sv
// Carrier between the port controller and the pin source mux.
// Assumes both ends sit in the controller clock domain.
`timescale 1ns/10ps
interface tpp_pin_if;
  import tpp_pkg::*;
  tpp_sel_t             sel;
  logic                 clk_fast;
  logic                 clk_half;
  logic                 clk_var;
  logic                 clk_slow;
  logic [TPP_PINS-1:0]  pin_lvl;

  modport ctrl (output sel, output clk_fast, output clk_half, output clk_var, output clk_slow, input pin_lvl);
  modport mux  (input sel, input clk_fast, input clk_half, input clk_var, input clk_slow, output pin_lvl);
endinterface

// ### tpp_pkg.sv
// Constants and types for the test point strap and debug port.
// Assumes one 25 MHz controller clock and an eight pin test point port.
package tpp_pkg;

  localparam int unsigned TPP_PINS       = 8;
  localparam int unsigned TPP_SRC_W      = 3;
  localparam int unsigned TPP_SYNC_LEN   = 3;

  // Strap field layout
  localparam int unsigned TPP_SCN_LSB    = 0;
  localparam int unsigned TPP_SCN_W      = 3;
  localparam int unsigned TPP_OPT_LSB    = 3;
  localparam int unsigned TPP_OPT_W      = 4;

  // Scenario patterns in the low strap bits
  localparam logic [TPP_SCN_W-1:0] TPP_SCN_QUIET  = 3'h0;
  localparam logic [TPP_SCN_W-1:0] TPP_SCN_CLKDBG = 3'h2;

  // Reset values
  localparam logic [TPP_PINS-1:0] TPP_STRAP_RST = 8'h00;
  localparam logic [TPP_PINS-1:0] TPP_PD_ALL    = 8'hFF;

  // Nominal rates of the forwarded core clocks, in kHz
  localparam int unsigned TPP_RATE_FAST_KHZ = 60000;
  localparam int unsigned TPP_RATE_HALF_KHZ = 30000;
  localparam int unsigned TPP_RATE_SLOW_KHZ = 7500;
  localparam int unsigned TPP_RATE_VMIN_KHZ = 700;
  localparam int unsigned TPP_RATE_VMAX_KHZ = 22500;

  // Source of one test point output
  typedef enum logic [TPP_SRC_W-1:0] {
    TPP_SRC_HIZ  = 3'h0,
    TPP_SRC_LOW  = 3'h1,
    TPP_SRC_HIGH = 3'h2,
    TPP_SRC_FAST = 3'h3,
    TPP_SRC_HALF = 3'h4,
    TPP_SRC_VAR  = 3'h5,
    TPP_SRC_SLOW = 3'h6
  } tpp_src_t;

  typedef tpp_src_t [TPP_PINS-1:0] tpp_sel_t;

  // Port state, one-hot
  typedef enum logic [1:0] {
    TPP_ST_HOLD = 2'h1,
    TPP_ST_RUN  = 2'h2
  } tpp_state_t;

endpackage

// ### tpp_src_mux.sv
// Per pin source mux that forwards core clocks or fixed levels.
// Assumes the selection is registered upstream; clocks pass without a flop on purpose.
`timescale 1ns/10ps
module tpp_src_mux (
  // Carrier
  tpp_pin_if.mux  pif
);
  import tpp_pkg::*;

  function automatic logic tpp_level(input tpp_src_t src, input logic f, input logic h, input logic v,
                                     input logic s);
    case (src)
      TPP_SRC_HIGH: tpp_level = 1'b1;
      TPP_SRC_FAST: tpp_level = f;
      TPP_SRC_HALF: tpp_level = h;
      TPP_SRC_VAR:  tpp_level = v;
      TPP_SRC_SLOW: tpp_level = s;
      default:      tpp_level = 1'b0;
    endcase
  endfunction

  // A flop here would resample clocks faster than CLK, so the path stays combinational
  for (genvar g = 0; g < TPP_PINS; g++) begin : g_pin
    assign pif.pin_lvl[g] = tpp_level(pif.sel[g], pif.clk_fast, pif.clk_half, pif.clk_var, pif.clk_slow);
  end
endmodule

// ### tpp_strap_model.sv
// Board side of the test point port: strap jumpers and pull-downs.
// Assumes the bench sets the jumper pattern and the device drives through OE.
`timescale 1ns/10ps
module tpp_strap_model (
  // Device side of each pin
  input  wire logic [tpp_pkg::TPP_PINS-1:0] oe,
  input  wire logic [tpp_pkg::TPP_PINS-1:0] drv,
  input  wire logic [tpp_pkg::TPP_PINS-1:0] pd_en,
  // Jumper pattern, one optional pull-up per pin
  input  wire logic [tpp_pkg::TPP_PINS-1:0] jumper_pu,
  // Resolved pin levels
  output logic      [tpp_pkg::TPP_PINS-1:0] pin
);
  import tpp_pkg::*;

  // Device drive beats the weak pulls; a pin with no pull floats to the opposite level
  always_comb begin
    for (int i = 0; i < TPP_PINS; i++) begin
      if (oe[i]) begin
        pin[i] = drv[i];
      end else if (jumper_pu[i]) begin
        pin[i] = 1'h1;
      end else if (pd_en[i]) begin
        pin[i] = 1'h0;
      end else begin
        pin[i] = ~drv[i];
      end
    end
  end
endmodule

// ### tpp_test_point_port.sv
// Test point port: straps captured at system reset release, then debug outputs.
// Assumes CLK is the 25 MHz controller clock and the core supplies the clocks to forward.
`timescale 1ns/10ps

// Functional notes
// - Pins are inputs in reset, outputs after unless selected hi-z
// - Capture straps at release, hold until reset
// - Sample only on reset low-to-high edge
// - Internal pull-down on every test point
// - Quiet pattern leaves all pins high impedance
// - Clock debug: pin0 fast, pin1 half clock
// - Clock debug: pin2 var, 3/5/6 high, 4 low, 7 slow
// - Strap selections are defaults, software may change
// - Straps 3 to 6 select mode option
module tpp_test_point_port #(
  parameter int unsigned N_PINS = tpp_pkg::TPP_PINS
) (
  // Clock, reset, enable
  input  wire logic                          CLK,
  input  wire logic                          RST,
  input  wire logic                          CE,
  // System reset pin, active low
  input  wire logic                          SYSTEM_RESET_N,
  // Test point pins
  input  wire logic [tpp_pkg::TPP_PINS-1:0]  TEST_POINT_PORT_I,
  output logic      [tpp_pkg::TPP_PINS-1:0]  TEST_POINT_PORT_O,
  output logic      [tpp_pkg::TPP_PINS-1:0]  TEST_POINT_PORT_OE,
  output logic      [tpp_pkg::TPP_PINS-1:0]  TEST_POINT_PORT_PD_EN,
  // Core clocks to forward
  input  wire logic                          CORE_CLK_FAST,
  input  wire logic                          CORE_CLK_HALF,
  input  wire logic                          CORE_CLK_VAR,
  input  wire logic                          CORE_CLK_SLOW,
  // Software selection
  input  wire logic                          SEL_WR,
  input  wire logic [tpp_pkg::TPP_PINS-1:0]  SEL_MASK,
  input  wire tpp_pkg::tpp_sel_t             SEL_CODE,
  // Captured configuration
  output logic      [tpp_pkg::TPP_OPT_W-1:0] MODE_OPT,
  output logic      [tpp_pkg::TPP_PINS-1:0]  STRAP_VALUE,
  output logic                               PORT_ACTIVE
);
  import tpp_pkg::*;

  if (N_PINS != TPP_PINS) begin : g_bad_pins
    $error("N_PINS must equal the strap width of the port");
  end

  typedef struct packed {
    tpp_state_t                            st;
    logic [TPP_SYNC_LEN-1:0]               rst_sh;
    logic [TPP_SYNC_LEN-1:0][TPP_PINS-1:0] pin_sh;
    logic [TPP_PINS-1:0]                   pin_agr;
    logic [TPP_PINS-1:0]                   strap;
    logic [TPP_PINS-1:0]                   ovr_mask;
    tpp_sel_t                              ovr_sel;
    tpp_sel_t                              sel;
    logic [TPP_PINS-1:0]                   oe;
  } tpp_regs_t;

  tpp_regs_t q_r;
  tpp_regs_t q_nxt;

  // Strap default for one pin
  function automatic tpp_src_t tpp_default(input logic [TPP_SCN_W-1:0] scn, input int unsigned pin);
    tpp_default = TPP_SRC_HIZ;
    if (scn == TPP_SCN_CLKDBG) begin
      case (pin)
        0:       tpp_default = TPP_SRC_FAST;
        1:       tpp_default = TPP_SRC_HALF;
        2:       tpp_default = TPP_SRC_VAR;
        4:       tpp_default = TPP_SRC_LOW;
        7:       tpp_default = TPP_SRC_SLOW;
        default: tpp_default = TPP_SRC_HIGH;
      endcase
    end
  endfunction

  logic rel_agree_hi;
  logic rel_agree_lo;

  always_comb begin
    q_nxt = q_r;
    rel_agree_hi = q_r.rst_sh[1] & q_r.rst_sh[2];
    rel_agree_lo = ~(q_r.rst_sh[1] | q_r.rst_sh[2]);
    // Three stage synchronisers; stage 0 feeds only stage 1
    q_nxt.rst_sh = {q_r.rst_sh[1:0], SYSTEM_RESET_N};
    q_nxt.pin_sh = {q_r.pin_sh[1:0], TEST_POINT_PORT_I};
    for (int i = 0; i < TPP_PINS; i++) begin
      if (q_r.pin_sh[1][i] == q_r.pin_sh[2][i]) begin
        q_nxt.pin_agr[i] = q_r.pin_sh[2][i];
      end
    end
    case (q_r.st)
      TPP_ST_HOLD: begin
        // Strap tracks the pins; the value at the release edge is the one kept
        q_nxt.strap    = q_nxt.pin_agr;
        q_nxt.ovr_mask = '0;
        // A write in the release edge is dropped: the port is still in hold here
        if (rel_agree_hi) begin
          q_nxt.st = TPP_ST_RUN;
        end
      end
      TPP_ST_RUN: begin
        // Strap frozen here; later pin changes wait for the next reset
        if (SEL_WR) begin
          for (int i = 0; i < TPP_PINS; i++) begin
            if (SEL_MASK[i]) begin
              q_nxt.ovr_sel[i] = SEL_CODE[i];
            end
          end
          q_nxt.ovr_mask = q_r.ovr_mask | SEL_MASK;
        end
        if (rel_agree_lo) begin
          q_nxt.st = TPP_ST_HOLD;
        end
      end
      default: q_nxt.st = TPP_ST_HOLD;
    endcase
    for (int i = 0; i < TPP_PINS; i++) begin
      q_nxt.sel[i] = q_nxt.ovr_mask[i] ? q_nxt.ovr_sel[i]
                   : tpp_default(q_nxt.strap[TPP_SCN_LSB +: TPP_SCN_W], i);
      // Drivers stay off during reset so straps can be read
      q_nxt.oe[i]  = (q_nxt.st == TPP_ST_RUN) && (q_nxt.sel[i] != TPP_SRC_HIZ);
    end
  end

  // Reset wins over a low clock enable
  always_ff @(posedge CLK) begin
    if (RST) begin
      q_r.st       <= TPP_ST_HOLD;
      q_r.rst_sh   <= '0;
      q_r.pin_sh   <= '0;
      q_r.pin_agr  <= TPP_STRAP_RST;
      q_r.strap    <= TPP_STRAP_RST;
      q_r.ovr_mask <= '0;
      q_r.ovr_sel  <= '{default: TPP_SRC_HIZ};
      q_r.sel      <= '{default: TPP_SRC_HIZ};
      q_r.oe       <= '0;
    end else if (CE) begin
      q_r <= q_nxt;
    end
  end

  tpp_pin_if pif ();

  assign pif.sel      = q_r.sel;
  assign pif.clk_fast = CORE_CLK_FAST;
  assign pif.clk_half = CORE_CLK_HALF;
  assign pif.clk_var  = CORE_CLK_VAR;
  assign pif.clk_slow = CORE_CLK_SLOW;

  tpp_src_mux u_mux (
    .pif (pif.mux)
  );

  assign TEST_POINT_PORT_O     = pif.pin_lvl;
  assign TEST_POINT_PORT_OE    = q_r.oe;
  // Pull-downs stay on always so an open pin reads zero; weak enough not to fight a driver
  assign TEST_POINT_PORT_PD_EN = TPP_PD_ALL;
  assign MODE_OPT              = q_r.strap[TPP_OPT_LSB +: TPP_OPT_W];
  assign STRAP_VALUE           = q_r.strap;
  assign PORT_ACTIVE           = (q_r.st == TPP_ST_RUN);

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_oe_in_hold: assert property ((q_r.st == TPP_ST_HOLD) |-> (TEST_POINT_PORT_OE == '0))
    else $error("Test point driven while system reset held");

  a_release_run: assert property (CE && (q_r.st == TPP_ST_HOLD) && q_r.rst_sh[1] && q_r.rst_sh[2]
                                  |=> PORT_ACTIVE && (STRAP_VALUE == $past(q_nxt.pin_agr)))
    else $error("Strap not captured at reset release");

  a_strap_frozen: assert property ((q_r.st == TPP_ST_RUN) ##1 (q_r.st == TPP_ST_RUN)
                                   |-> $stable(STRAP_VALUE))
    else $error("Strap changed while running");

  // Run is entered only from an agreed high reset pin, never from a glitch
  a_no_early_run: assert property ($rose(PORT_ACTIVE) |-> $past(q_r.rst_sh[1] && q_r.rst_sh[2]))
    else $error("Port left hold without agreed release");

  a_pulldown_on: assert property (TEST_POINT_PORT_PD_EN == TPP_PD_ALL)
    else $error("Pull-down disabled");

  a_quiet_hiz: assert property (PORT_ACTIVE && (q_r.ovr_mask == '0)
                                && (STRAP_VALUE[TPP_SCN_LSB +: TPP_SCN_W] == TPP_SCN_QUIET)
                                |-> (TEST_POINT_PORT_OE == '0))
    else $error("Quiet scenario drives a pin");

  a_clkdbg_fast: assert property (PORT_ACTIVE && (q_r.ovr_mask == '0)
                                  && (STRAP_VALUE[TPP_SCN_LSB +: TPP_SCN_W] == TPP_SCN_CLKDBG)
                                  |-> (TEST_POINT_PORT_O[0] == CORE_CLK_FAST)
                                      && (TEST_POINT_PORT_O[1] == CORE_CLK_HALF)
                                      && (TEST_POINT_PORT_OE[1:0] == 2'h3))
    else $error("Clock debug pins 0 or 1 wrong");

  a_clkdbg_rest: assert property (PORT_ACTIVE && (q_r.ovr_mask == '0)
                                  && (STRAP_VALUE[TPP_SCN_LSB +: TPP_SCN_W] == TPP_SCN_CLKDBG)
                                  |-> (TEST_POINT_PORT_O[6:3] == 4'hD) && (TEST_POINT_PORT_O[2] == CORE_CLK_VAR)
                                      && (TEST_POINT_PORT_O[7] == CORE_CLK_SLOW)
                                      && (TEST_POINT_PORT_OE == 8'hFF))
    else $error("Clock debug pins 2 to 7 wrong");

  a_sw_override: assert property (CE && PORT_ACTIVE && SEL_WR && SEL_MASK[0] ##1 PORT_ACTIVE
                                  |-> (q_r.sel[0] == $past(SEL_CODE[0])))
    else $error("Software selection not applied");

  // Software overrides are wiped whenever the system reset pin is held
  a_hold_clears: assert property (CE && (q_r.st == TPP_ST_HOLD) |=> (q_r.ovr_mask == '0))
    else $error("Software override survived system reset");

  a_mode_option: assert property (CE && (q_r.st == TPP_ST_HOLD) && rel_agree_hi
                                  |=> (MODE_OPT == $past(q_nxt.pin_agr[TPP_OPT_LSB +: TPP_OPT_W])))
    else $error("Mode option differs from captured straps");

  // Clock enable low must freeze the synchronisers as well as the configuration
  a_ce_freeze: assert property (!CE |=> $stable(q_r))
    else $error("State moved while clock enable low");

  c_release:  cover property (q_r.st == TPP_ST_HOLD ##1 q_r.st == TPP_ST_RUN);
  c_clkdbg:   cover property (PORT_ACTIVE && STRAP_VALUE[TPP_SCN_LSB +: TPP_SCN_W] == TPP_SCN_CLKDBG);
  c_override: cover property (PORT_ACTIVE && SEL_WR && CE);
  c_reassert: cover property (q_r.st == TPP_ST_RUN ##1 q_r.st == TPP_ST_HOLD);
  c_frozen:   cover property (PORT_ACTIVE && SEL_WR && !CE);
endmodule
